//--- csfsm_top.sv
// Clock source selection, fail-safe clock monitor and oscillator registers behind APB
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module csfsm_top
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_clk,
	input  wire logic        t1_clk,
	input  wire logic        lf_clk,
	input  wire logic        pll_rdy,
	input  wire logic        hf_rdy,
	input  wire logic        hf_lock,
	input  wire logic        hf_stab,
	input  wire logic        mf_rdy,
	input  wire logic        lf_rdy,
	input  wire logic        t1_rdy,
	input  wire logic        fail_monitor_enable,
	input  wire logic        config_pll_enable,
	input  wire logic [2:0]  cfg_fosc,
	input  wire logic        sleep_req,
	input  wire logic        timer1_osc_enable,
	output logic      [1:0]  sys_clk_sel,
	output logic      [3:0]  internal_freq_select,
	output logic      [5:0]  freq_trim,
	output logic             pll_on,
	output logic             osc_fail_irq
);
	csfsm_pkg::csfsm_state_type state_q;
	csfsm_pkg::csfsm_state_type state_d;

	logic       s_ext;
	logic       s_t1;
	logic       s_lf;
	logic       s_fcm;
	logic       s_plle;
	logic [2:0] s_fosc;
	logic       mon_clk;
	logic       mon_fall;
	logic       lf_rise;
	logic       samp_rise;
	logic       samp_fall;
	logic       crystal;
	logic       det_active;
	logic       ext_running;
	logic [7:0] stat;
	logic       wr;
	logic       rd_phase;
	logic [1:0] src_new;

	assign s_ext     = state_q.sync2[14];
	assign s_t1      = state_q.sync2[13];
	assign s_lf      = state_q.sync2[12];
	assign s_fcm     = state_q.sync2[4];
	assign s_plle    = state_q.sync2[3];
	assign s_fosc    = state_q.sync2[2:0];
	// Monitored source follows the selection so timer1 is watched too
	assign mon_clk   = (state_q.ctrl[1:0] == csfsm_pkg::SRC_TIMER1) ? s_t1 : s_ext;
	assign mon_fall  = state_q.mon_prev & ~mon_clk;
	assign lf_rise   = s_lf & ~state_q.lf_prev;
	assign samp_rise = lf_rise && (state_q.div == csfsm_pkg::DIV_HALF);
	assign samp_fall = lf_rise && (state_q.div == csfsm_pkg::DIV_LAST);
	assign crystal   = (s_fosc <= csfsm_pkg::FOSC_HS);
	assign det_active = s_fcm && state_q.su_done && !state_q.fail_safe
		&& (state_q.sel != csfsm_pkg::SEL_INT);
	assign ext_running = (state_q.sel == csfsm_pkg::SEL_FOSC);
	assign stat      = {timer1_osc_enable ? state_q.sync2[5] : 1'b1,
		state_q.sync2[11], ext_running, state_q.sync2[10], state_q.sync2[9],
		state_q.sync2[8], state_q.sync2[7], state_q.sync2[6]};
	assign rd_phase  = psel && penable && !state_q.pready;
	assign wr        = psel && penable && pwrite && state_q.pready;
	assign src_new   = pwdata[1:0];

	always_comb
	begin
		state_d = state_q;
		state_d.sync1 = {ext_clk, t1_clk, lf_clk, pll_rdy, hf_rdy, hf_lock, mf_rdy, lf_rdy, hf_stab,
			t1_rdy, fail_monitor_enable, config_pll_enable, cfg_fosc};
		state_d.sync2 = state_q.sync1;
		state_d.mon_prev = mon_clk;
		state_d.lf_prev = s_lf;
		if (lf_rise)
		begin
			state_d.div = state_q.div + 6'h01;
		end
		// Clear wins on a coincident edge: the sample edge opens a new window
		if (samp_rise)
		begin
			state_d.latch = 1'b0;
		end
		else if (mon_fall)
		begin
			state_d.latch = 1'b1;
		end
		state_d.fail_raw = samp_fall && !state_q.latch;
		state_d.fail_m1 = state_q.fail_raw;
		state_d.fail_m2 = state_q.fail_m1;
		if (state_q.fail_m2 && det_active)
		begin
			state_d.fail_safe = 1'b1;
		end

		// Start-up timer on the monitored oscillator
		if (!state_q.su_done)
		begin
			if (!crystal && state_q.ctrl[1:0] == csfsm_pkg::SRC_STRAP)
			begin
				state_d.su_done = 1'b1;
			end
			else if (mon_fall)
			begin
				state_d.su_cnt = state_q.su_cnt + 11'h001;
				if (state_q.su_cnt == csfsm_pkg::SU_LAST)
				begin
					state_d.su_done = 1'b1;
				end
			end
		end
		else if (state_q.recover)
		begin
			state_d.fail_safe = 1'b0;
			state_d.recover = 1'b0;
		end

		// APB register access, one wait state
		state_d.pready = rd_phase;
		state_d.pslverr = 1'b0;
		if (rd_phase)
		begin
			state_d.prdata = 32'h0000_0000;
			case (paddr)
				csfsm_pkg::CTRL_OFFSET: state_d.prdata[7:0] = state_q.ctrl;
				csfsm_pkg::STAT_OFFSET: state_d.prdata[7:0] = stat;
				csfsm_pkg::TUNE_OFFSET: state_d.prdata[5:0] = state_q.tune;
				csfsm_pkg::IRQF_OFFSET: state_d.prdata[csfsm_pkg::IRQ_BIT] = state_q.flag;
				csfsm_pkg::IRQE_OFFSET: state_d.prdata[csfsm_pkg::IRQ_BIT] = state_q.irq_en;
				default: state_d.pslverr = 1'b1;
			endcase
		end
		if (wr)
		begin
			case (paddr)
				csfsm_pkg::CTRL_OFFSET:
				begin
					state_d.ctrl = pwdata[7:0];
					state_d.ctrl[csfsm_pkg::CTRL_ZERO_BIT] = 1'b0;
					if (src_new != state_q.ctrl[1:0])
					begin
						state_d.su_cnt = 11'h000;
						state_d.su_done = 1'b0;
						state_d.fail_safe = state_d.fail_safe && !src_new[1];
						state_d.recover = !src_new[1];
					end
				end
				csfsm_pkg::TUNE_OFFSET: state_d.tune = pwdata[5:0];
				csfsm_pkg::IRQF_OFFSET:
				begin
					if (!pwdata[csfsm_pkg::IRQ_BIT] && !state_q.fail_safe)
					begin
						state_d.flag = 1'b0;
					end
				end
				csfsm_pkg::IRQE_OFFSET: state_d.irq_en = pwdata[csfsm_pkg::IRQ_BIT];
				default: state_d.flag = state_d.flag;
			endcase
		end
		// Sleep aborts start-up and drops the condition
		if (sleep_req)
		begin
			state_d.su_cnt = 11'h000;
			state_d.su_done = 1'b0;
			state_d.fail_safe = 1'b0;
			state_d.recover = 1'b0;
		end
		// Hardware set wins over a software clear in the same cycle
		if (state_q.fail_m2 && det_active)
		begin
			state_d.flag = 1'b1;
		end
		state_d.irq = state_q.flag && state_q.irq_en;

		// Two-speed start-up: internal until the timer runs out
		if (state_d.ctrl[1])
		begin
			state_d.sel = csfsm_pkg::SEL_INT;
		end
		else if (state_d.fail_safe || !state_d.su_done)
		begin
			state_d.sel = csfsm_pkg::SEL_INT;
		end
		else if (state_d.ctrl[1:0] == csfsm_pkg::SRC_TIMER1)
		begin
			state_d.sel = csfsm_pkg::SEL_T1;
		end
		else if (s_fosc == csfsm_pkg::FOSC_INTERNAL)
		begin
			state_d.sel = csfsm_pkg::SEL_INT;
		end
		else
		begin
			state_d.sel = csfsm_pkg::SEL_FOSC;
		end
		state_d.pll_on = s_plle || state_d.ctrl[csfsm_pkg::CTRL_PLL_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= '0;
			state_q.ctrl <= csfsm_pkg::CTRL_RESET;
			state_q.tune <= csfsm_pkg::TUNE_RESET;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign prdata               = state_q.prdata;
	assign pready               = state_q.pready;
	assign pslverr              = state_q.pslverr;
	assign sys_clk_sel          = state_q.sel;
	assign internal_freq_select = state_q.ctrl[6:3];
	assign freq_trim            = state_q.tune;
	assign pll_on               = state_q.pll_on;
	assign osc_fail_irq         = state_q.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ext_status_sel: assert property (stat[5] == (sys_clk_sel == csfsm_pkg::SEL_FOSC))
		else $error("startup status disagrees with clock selection");
	a_fail_after_timer: assert property ($rose(state_q.fail_safe) |-> $past(state_q.su_done))
		else $error("failure raised before start-up timer expiry");
	a_div_wraps: assert property (samp_fall |=> state_q.div == 6'h00)
		else $error("sample divider did not wrap after 64 edges");
	a_latch_cleared: assert property (samp_rise |=> !state_q.latch)
		else $error("detector latch not cleared by sample rise");
	a_fail_detect: assert property (samp_fall && !state_q.latch |=> state_q.fail_raw ##2 state_q.fail_m2)
		else $error("missed failure window not reported through synchroniser");
	a_fail_internal: assert property (state_q.fail_safe |-> sys_clk_sel == csfsm_pkg::SEL_INT)
		else $error("fail-safe condition without internal clock");
	a_fail_sets_flag: assert property ($rose(state_q.fail_safe) |-> state_q.flag)
		else $error("failure did not set flag");
	a_irq_gate: assert property (state_q.flag && state_q.irq_en |=> osc_fail_irq)
		else $error("interrupt not raised");
	a_flag_hold: assert property (wr && paddr == csfsm_pkg::IRQF_OFFSET && state_q.fail_safe |=> state_q.flag)
		else $error("flag cleared during fail-safe condition");
	a_pll_forced: assert property (s_plle |=> pll_on)
		else $error("strap PLL enable not honoured");
	a_ctrl_bit2: assert property (state_q.pready && paddr == csfsm_pkg::CTRL_OFFSET |-> !prdata[2])
		else $error("unimplemented control bit reads one");

	a_tune_read_zero: assert property (pready && paddr == csfsm_pkg::TUNE_OFFSET |-> prdata[7:6] == 2'b00)
		else $error("tuning upper bits read one");

	a_tune_write: assert property (wr && paddr == csfsm_pkg::TUNE_OFFSET |=> freq_trim == $past(pwdata[5:0]))
		else $error("tuning write lost");

	a_ctrl_write: assert property (wr && paddr == csfsm_pkg::CTRL_OFFSET |=> state_q.ctrl == ($past(pwdata[7:0]) & 8'hfb))
		else $error("control write stored wrong value");

	a_freq_out: assert property (wr && paddr == csfsm_pkg::CTRL_OFFSET |=> internal_freq_select == $past(pwdata[6:3]))
		else $error("frequency select output not updated");

	a_stat_read: assert property (pready && paddr == csfsm_pkg::STAT_OFFSET |-> prdata[7:0] == $past(stat))
		else $error("status read data wrong");

	a_read_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read data bits not zero");

	a_pready_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");

	a_pready_answer: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered after one wait state");

	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("error response without ready");

	a_irqe_write: assert property (wr && paddr == csfsm_pkg::IRQE_OFFSET |=> state_q.irq_en == $past(pwdata[7]))
		else $error("interrupt enable write lost");

	a_irq_low: assert property (!state_q.flag || !state_q.irq_en |=> !osc_fail_irq)
		else $error("interrupt raised without flag and enable");

	a_flag_sticky: assert property (state_q.flag && !(wr && paddr == csfsm_pkg::IRQF_OFFSET) |=> state_q.flag)
		else $error("flag dropped without software clear");

	a_flag_clear: assert property (wr && paddr == csfsm_pkg::IRQF_OFFSET && !pwdata[7] && !state_q.fail_safe
		&& !(state_q.fail_m2 && det_active) |=> !state_q.flag)
		else $error("flag clear ignored outside fail-safe condition");

	a_detect_sets: assert property (state_q.fail_m2 && det_active && !sleep_req && !wr
		|=> state_q.fail_safe && state_q.flag)
		else $error("reported failure not acted on");

	a_detect_off: assert property (!s_fcm |=> !$rose(state_q.fail_safe))
		else $error("failure raised with monitor disabled");

	a_div_steps: assert property (lf_rise |=> state_q.div == $past(state_q.div) + 6'h01)
		else $error("sample divider missed an edge");

	a_div_hold: assert property (!lf_rise |=> $stable(state_q.div))
		else $error("sample divider moved without an edge");

	a_latch_set: assert property (mon_fall && !samp_rise |=> state_q.latch)
		else $error("detector latch not set by clock fall");

	a_latch_hold: assert property (!mon_fall && !samp_rise |=> $stable(state_q.latch))
		else $error("detector latch changed without an edge");

	a_raw_pulse: assert property (!samp_fall |=> !state_q.fail_raw)
		else $error("failure reported outside window end");

	a_no_false_fail: assert property (samp_fall && state_q.latch |=> !state_q.fail_raw)
		else $error("failure reported although clock fell");

	a_sync_chain: assert property (state_q.fail_m1 |=> state_q.fail_m2)
		else $error("synchroniser stage lost failure");

	a_fail_hold: assert property (state_q.fail_safe && !state_q.recover && !sleep_req && !wr |=> state_q.fail_safe)
		else $error("fail-safe condition dropped on its own");

	a_recover_clear: assert property (state_q.recover && state_q.su_done |=> !state_q.fail_safe)
		else $error("timer expiry did not clear condition");

	a_sleep_clears: assert property (sleep_req |=> !state_q.fail_safe && !state_q.su_done)
		else $error("sleep did not clear condition and timer");

	a_src_int_clear: assert property (wr && paddr == csfsm_pkg::CTRL_OFFSET && src_new[1]
		&& src_new != state_q.ctrl[1:0] |=> !state_q.fail_safe)
		else $error("switch to internal did not clear condition");

	a_src_restart: assert property (wr && paddr == csfsm_pkg::CTRL_OFFSET && src_new != state_q.ctrl[1:0]
		|=> !state_q.su_done && state_q.su_cnt == 11'h000)
		else $error("source change did not restart timer");

	a_timer_skip: assert property (!state_q.su_done && !crystal && state_q.ctrl[1:0] == csfsm_pkg::SRC_STRAP
		&& !sleep_req && !wr |=> state_q.su_done)
		else $error("timer not skipped for clock or RC mode");

	a_timer_wait: assert property (!state_q.su_done && !mon_fall
		&& (crystal || state_q.ctrl[1:0] != csfsm_pkg::SRC_STRAP) |=> !state_q.su_done)
		else $error("timer expired without clock fall");

	a_timer_expiry: assert property (!state_q.su_done && mon_fall && state_q.su_cnt == csfsm_pkg::SU_LAST
		&& !sleep_req && !wr |=> state_q.su_done)
		else $error("timer did not expire at last count");

	a_timer_keep: assert property (state_q.su_done && !sleep_req && !wr |=> state_q.su_done)
		else $error("timer done dropped on its own");

	a_two_speed: assert property (!state_q.su_done |-> sys_clk_sel == csfsm_pkg::SEL_INT)
		else $error("external clock used before timer expiry");

	a_fosc_only: assert property (sys_clk_sel == csfsm_pkg::SEL_FOSC
		|-> state_q.ctrl[1:0] == csfsm_pkg::SRC_STRAP && state_q.su_done && !state_q.fail_safe)
		else $error("external clock selected when not allowed");

	a_src_t1: assert property (state_q.ctrl[1:0] == csfsm_pkg::SRC_TIMER1 && state_q.su_done
		&& !state_q.fail_safe |-> sys_clk_sel == csfsm_pkg::SEL_T1)
		else $error("timer1 oscillator not selected");

	a_src_int: assert property (state_q.ctrl[1] |-> sys_clk_sel == csfsm_pkg::SEL_INT)
		else $error("internal block not selected");

	a_t1_only: assert property (sys_clk_sel == csfsm_pkg::SEL_T1 |-> state_q.ctrl[1:0] == csfsm_pkg::SRC_TIMER1)
		else $error("timer1 oscillator selected without request");

	a_sel_legal: assert property (sys_clk_sel != 2'h3)
		else $error("illegal clock selection code");

	a_pll_soft: assert property (!s_plle |=> pll_on == state_q.ctrl[csfsm_pkg::CTRL_PLL_BIT])
		else $error("software PLL bit not followed");

	c_failure: cover property ($rose(state_q.fail_safe));
	c_recovery: cover property ($fell(state_q.fail_safe) && state_q.sel != csfsm_pkg::SEL_INT ##[0:4] ext_running);
	c_flag_cleared: cover property ($fell(state_q.flag));
	c_timer1_run: cover property (sys_clk_sel == csfsm_pkg::SEL_T1);
	c_irq_raised: cover property ($rose(osc_fail_irq));
endmodule // csfsm_top

//--- csfsm_pkg.sv
// Constants, register map and state type of the clock select and fail-safe monitor
// Contract
// - Status bit 5 shows running from external clock
// - Failure flagged only after start-up timer expiry
// - Strap enables monitor for every external mode
// - Sample clock is low-frequency oscillator over 64
// - Latch set by clock fall, cleared by sample rise
// - Failure when sample half-period passes without fall
// - Failure moves clock internal and sets flag
// - Interrupt while flag and enable both set
// - Stay internal until firmware switches back
// - Fallback frequency comes from frequency select field
// - Reset, sleep or source change clears condition
// - Source change restarts timer, expiry resumes external
// - Flag not clearable while condition persists
// - External clock and RC modes skip timer
// - Monitor enabled implies two-speed start-up
// - Strap PLL enable overrides software PLL bit
// - Frequency field decoding, reset value 0111
// - Source select 1x internal, 01 timer1, 00 strap
// - Status bit 7 timer1 ready or one
// - Locked and stable accuracy flags
// - Tuning field is a signed offset
// - Control bit 2 reads zero, ignores writes
// - Start-up timer counts 1024 oscillator cycles
package csfsm_pkg;
	localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]  STAT_OFFSET   = 8'h04;
	localparam logic [7:0]  TUNE_OFFSET   = 8'h08;
	localparam logic [7:0]  IRQF_OFFSET   = 8'h0c;
	localparam logic [7:0]  IRQE_OFFSET   = 8'h10;
	localparam logic [7:0]  CTRL_RESET    = 8'h38;
	localparam logic [5:0]  TUNE_RESET    = 6'h00;
	localparam int          CTRL_PLL_BIT  = 7;
	localparam int          CTRL_ZERO_BIT = 2;
	localparam int          IRQ_BIT       = 7;
	localparam logic [10:0] SU_LAST       = 11'h3ff;
	localparam logic [5:0]  DIV_HALF      = 6'h1f;
	localparam logic [5:0]  DIV_LAST      = 6'h3f;
	localparam logic [2:0]  FOSC_HS       = 3'h2;
	localparam logic [2:0]  FOSC_INTERNAL = 3'h4;
	localparam logic [1:0]  SRC_STRAP     = 2'h0;
	localparam logic [1:0]  SRC_TIMER1    = 2'h1;
	localparam logic [1:0]  SEL_INT       = 2'h0;
	localparam logic [1:0]  SEL_FOSC      = 2'h1;
	localparam logic [1:0]  SEL_T1        = 2'h2;
	localparam int          PIN_COUNT     = 15;

	typedef struct packed {
		logic [14:0] sync1;
		logic [14:0] sync2;
		logic        mon_prev;
		logic        lf_prev;
		logic [5:0]  div;
		logic        latch;
		logic        fail_raw;
		logic        fail_m1;
		logic        fail_m2;
		logic [10:0] su_cnt;
		logic        su_done;
		logic        fail_safe;
		logic        recover;
		logic        flag;
		logic        irq_en;
		logic        irq;
		logic [7:0]  ctrl;
		logic [5:0]  tune;
		logic [1:0]  sel;
		logic        pll_on;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} csfsm_state_type;
endpackage

//--- csfsm_osc_model.sv
// Behavioural model of a free-running oscillator that can be made to fail
`timescale 1ns/1ps
module csfsm_osc_model
#(
	parameter realtime HALF = 100.0
)
(
	input  wire logic run,
	output logic      clk_out
);
	initial clk_out = 1'b0;
	// A dead oscillator freezes at its last level, as a broken crystal would
	always #(HALF) if (run) clk_out = ~clk_out;
endmodule // csfsm_osc_model

//--- tb_clock_select_fail_safe_monitor.sv
// Self-checking bench for the clock select and fail-safe monitor block
`timescale 1ns/1ps
module tb_clock_select_fail_safe_monitor;
	typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] x; logic e;} csfsm_row_type;
	logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic          ext_run = 1'b1, fme = 1'b1, cpll = 1'b0, sleep_req = 1'b0, t1en = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0, prdata, rd;
	logic          pready, pslverr, er, pll_on, irq, ext_clk, t1_clk, lf_clk;
	logic [6:0]    pins = 7'h7f;
	logic [2:0]    fosc = 3'h3;
	logic [1:0]    sel;
	logic [3:0]    ifs;
	logic [5:0]    trim;
	int            fails, comparisons;
	csfsm_row_type rows [5];

	always #10 pclk = ~pclk;

	csfsm_osc_model #(.HALF(101.5)) ext_osc (.run(ext_run), .clk_out(ext_clk));
	csfsm_osc_model #(.HALF(150.0)) t1_osc (.run(1'b1), .clk_out(t1_clk));
	// Low-frequency internal oscillator, kept fast so the sample window stays short
	csfsm_osc_model #(.HALF(78.5)) lf_osc (.run(1'b1), .clk_out(lf_clk));

	csfsm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_clk(ext_clk), .t1_clk(t1_clk), .lf_clk(lf_clk), .pll_rdy(pins[6]), .hf_rdy(pins[5]),
		.hf_lock(pins[4]), .hf_stab(pins[1]), .mf_rdy(pins[3]), .lf_rdy(pins[2]), .t1_rdy(pins[0]),
		.fail_monitor_enable(fme), .config_pll_enable(cpll), .cfg_fosc(fosc), .sleep_req(sleep_req),
		.timer1_osc_enable(t1en), .sys_clk_sel(sel), .internal_freq_select(ifs), .freq_trim(trim),
		.pll_on(pll_on), .osc_fail_irq(irq));

	task final_report;
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_sel(input logic [1:0] s, input int lim);
		int n;
		n = 0;
		while (sel !== s && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		chk({30'h0, sel}, {30'h0, s});
	endtask

	task do_reset(input logic [2:0] f);
		presetn <= 1'b0;
		fosc <= f;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	initial
	begin
		#2000000;
		fails++;
		final_report;
	end

	initial
	begin
		rows[0] = {csfsm_pkg::CTRL_OFFSET, 32'h7c, 32'h78, 1'b0};
		rows[1] = {csfsm_pkg::TUNE_OFFSET, 32'hff, 32'h3f, 1'b0};
		rows[2] = {csfsm_pkg::TUNE_OFFSET, 32'h20, 32'h20, 1'b0};
		rows[3] = {csfsm_pkg::IRQE_OFFSET, 32'h80, 32'h80, 1'b0};
		rows[4] = {8'h14, 32'h55, 32'h00, 1'b1};
		do_reset(3'h3);
		wait_sel(csfsm_pkg::SEL_FOSC, 50);
		apb(1'b0, csfsm_pkg::CTRL_OFFSET, 32'h0);
		chk(rd, 32'h38);
		chk({28'h0, ifs}, 32'h7);
		chk({31'h0, pll_on}, 32'h0);
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].x);
			chk({31'h0, er}, {31'h0, rows[i].e});
		end
		chk({26'h0, trim}, 32'h20);
		for (int i = 0; i < 2; i++)
		begin
			pins <= i ? 7'h2a : 7'h55;
			t1en <= i ? 1'b0 : 1'b1;
			repeat (4) @(posedge pclk);
			apb(1'b0, csfsm_pkg::STAT_OFFSET, 32'h0);
			chk(rd, {24'h0, t1en ? pins[0] : 1'b1, pins[6], 1'b1, pins[5:1]});
		end
		apb(1'b1, csfsm_pkg::CTRL_OFFSET, 32'hb8);
		repeat (2) @(posedge pclk);
		chk({31'h0, pll_on}, 32'h1);
		cpll <= 1'b1;
		apb(1'b1, csfsm_pkg::CTRL_OFFSET, 32'h50);
		repeat (6) @(posedge pclk);
		chk({31'h0, pll_on}, 32'h1);
		cpll <= 1'b0;
		repeat (6) @(posedge pclk);
		chk({31'h0, pll_on}, 32'h0);
		ext_run <= 1'b0;
		wait_sel(csfsm_pkg::SEL_INT, 2000);
		apb(1'b0, csfsm_pkg::IRQF_OFFSET, 32'h0);
		chk(rd, 32'h80);
		chk({31'h0, irq}, 32'h1);
		chk({28'h0, ifs}, 32'ha);
		apb(1'b0, csfsm_pkg::STAT_OFFSET, 32'h0);
		chk({31'h0, rd[5]}, 32'h0);
		apb(1'b1, csfsm_pkg::IRQF_OFFSET, 32'h0);
		apb(1'b0, csfsm_pkg::IRQF_OFFSET, 32'h0);
		chk(rd, 32'h80);
		ext_run <= 1'b1;
		@(posedge pclk);
		sleep_req <= 1'b1;
		@(posedge pclk);
		sleep_req <= 1'b0;
		wait_sel(csfsm_pkg::SEL_FOSC, 100);
		apb(1'b1, csfsm_pkg::IRQF_OFFSET, 32'h0);
		apb(1'b0, csfsm_pkg::IRQF_OFFSET, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, csfsm_pkg::CTRL_OFFSET, 32'h52);
		wait_sel(csfsm_pkg::SEL_INT, 4);
		apb(1'b1, csfsm_pkg::CTRL_OFFSET, 32'h51);
		wait_sel(csfsm_pkg::SEL_T1, 20000);
		apb(1'b1, csfsm_pkg::CTRL_OFFSET, 32'h50);
		wait_sel(csfsm_pkg::SEL_FOSC, 200);
		// Crystal mode: a dead clock during start-up must go unflagged
		do_reset(3'h2);
		ext_run <= 1'b0;
		repeat (1000) @(posedge pclk);
		apb(1'b0, csfsm_pkg::IRQF_OFFSET, 32'h0);
		chk(rd, 32'h0);
		chk({30'h0, sel}, {30'h0, csfsm_pkg::SEL_INT});
		ext_run <= 1'b1;
		repeat (5000) @(posedge pclk);
		chk({30'h0, sel}, {30'h0, csfsm_pkg::SEL_INT});
		wait_sel(csfsm_pkg::SEL_FOSC, 8000);
		final_report;
	end
endmodule // tb_clock_select_fail_safe_monitor
